// [bus_master.sv]
// processor master end of the backplane bus: cycles, dma grant, traps
`timescale 1ns/100ps
module bus_master (
    input wire logic clk,
    input wire logic arst_n,
    bus_if.master bus,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_byte,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic [15:0] psw,
    output logic req_ready_ff,
    output logic done_ff,
    output logic [15:0] rdata_ff,
    output logic trap_ff,
    output logic [15:0] trap_vector_ff
);
    bus_pkg::master_state_e state_ff, nxt_state;
    logic [15:0] addr_ff, nxt_addr;
    logic [15:0] wdata_ff, nxt_wdata;
    logic write_ff, nxt_write;
    logic byte_ff, nxt_byte;
    logic [1:0] skew_ff, nxt_skew;
    logic pok_prev_ff, nxt_pok_prev;
    logic [15:0] dal_ff, nxt_dal;
    logic dal_oe_ff, nxt_dal_oe;
    logic sync_ff, nxt_sync;
    logic din_ff, nxt_din;
    logic dout_ff, nxt_dout;
    logic wtbt_ff, nxt_wtbt;
    logic grant_ff, nxt_grant;
    logic nxt_req_ready, nxt_done, nxt_trap;
    logic [15:0] nxt_rdata, nxt_trap_vector;

    assign bus.dal_m = dal_ff;
    assign bus.dal_m_oe = dal_oe_ff;
    assign bus.address_sync = sync_ff;
    assign bus.input_data_strobe = din_ff;
    assign bus.output_data_strobe = dout_ff;
    assign bus.write_byte_select = wtbt_ff;
    assign bus.dma_grant_out = grant_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_addr = addr_ff;
        nxt_wdata = wdata_ff;
        nxt_write = write_ff;
        nxt_byte = byte_ff;
        nxt_skew = skew_ff;
        nxt_pok_prev = bus.power_ok;
        nxt_dal = dal_ff;
        nxt_dal_oe = dal_oe_ff;
        nxt_sync = sync_ff;
        nxt_din = din_ff;
        nxt_dout = dout_ff;
        nxt_wtbt = wtbt_ff;
        nxt_grant = grant_ff;
        nxt_req_ready = 1'b0;
        nxt_done = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_trap = 1'b0;
        nxt_trap_vector = trap_vector_ff;
        // power-fail wins over an event raised in the same cycle
        if (pok_prev_ff && !bus.power_ok) begin
            nxt_trap = 1'b1;
            nxt_trap_vector = bus_pkg::POWER_FAIL_VECTOR;
        end else if (bus.external_event_request && !psw[bus_pkg::PSW_PRIO_BIT]
                && state_ff == bus_pkg::M_IDLE) begin
            nxt_trap = 1'b1;
            nxt_trap_vector = bus_pkg::EVENT_VECTOR;
        end
        unique case (state_ff)
            bus_pkg::M_IDLE: begin
                nxt_req_ready = 1'b1;
                // dma wins only between cycles, when sync is not ours
                if (bus.dma_request) begin
                    nxt_grant = 1'b1;
                    nxt_req_ready = 1'b0;
                    nxt_state = bus_pkg::M_DMA;
                end else if (req_valid && req_ready_ff) begin
                    nxt_req_ready = 1'b0;
                    nxt_addr = req_addr;
                    nxt_wdata = req_wdata;
                    nxt_write = req_write;
                    nxt_byte = req_byte;
                    // address goes out a cycle ahead of sync
                    nxt_dal = req_addr;
                    nxt_dal_oe = 1'b1;
                    nxt_wtbt = req_write;
                    nxt_state = bus_pkg::M_ADDR;
                end
            end
            bus_pkg::M_ADDR: begin
                // address must still stand when the slave first sees sync
                nxt_sync = 1'b1;
                nxt_skew = bus_pkg::DESKEW_RESET;
                nxt_state = bus_pkg::M_SKEW;
            end
            bus_pkg::M_SKEW: begin
                if (!write_ff) begin
                    nxt_dal_oe = 1'b0;
                    nxt_wtbt = 1'b0;
                    nxt_din = 1'b1;
                    nxt_state = bus_pkg::M_STRB;
                end else if (skew_ff == bus_pkg::DESKEW_CYCLES) begin
                    // data settles on the lines before the strobe goes out
                    nxt_dout = 1'b1;
                    nxt_state = bus_pkg::M_STRB;
                end else begin
                    if (skew_ff == bus_pkg::DESKEW_RESET) begin
                        nxt_dal = wdata_ff;
                        nxt_wtbt = byte_ff;
                    end
                    nxt_skew = skew_ff + 2'h1;
                end
            end
            bus_pkg::M_STRB: begin
                if (bus.slave_reply) begin
                    if (!write_ff) begin
                        nxt_rdata = bus.mux_data_address_lines;
                    end
                    nxt_din = 1'b0;
                    nxt_dout = 1'b0;
                    nxt_state = bus_pkg::M_DONE;
                end
            end
            bus_pkg::M_DONE: begin
                // next strobe waits for reply to drop
                if (!bus.slave_reply) begin
                    nxt_sync = 1'b0;
                    nxt_dal_oe = 1'b0;
                    nxt_wtbt = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = bus_pkg::M_IDLE;
                end
            end
            bus_pkg::M_DMA: begin
                if (bus.dma_select_ack) begin
                    nxt_grant = 1'b0;
                // bus comes back once the dma device has let go
                end else if (!grant_ff && !bus.dma_request) begin
                    nxt_state = bus_pkg::M_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= bus_pkg::M_IDLE;
            addr_ff <= bus_pkg::ADDR_RESET;
            wdata_ff <= bus_pkg::DATA_RESET;
            write_ff <= 1'b0;
            byte_ff <= 1'b0;
            skew_ff <= bus_pkg::DESKEW_RESET;
            pok_prev_ff <= 1'b0;
            dal_ff <= bus_pkg::DATA_RESET;
            dal_oe_ff <= 1'b0;
            sync_ff <= 1'b0;
            din_ff <= 1'b0;
            dout_ff <= 1'b0;
            wtbt_ff <= 1'b0;
            grant_ff <= 1'b0;
            req_ready_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= bus_pkg::DATA_RESET;
            trap_ff <= 1'b0;
            trap_vector_ff <= bus_pkg::ADDR_RESET;
        end else begin
            state_ff <= nxt_state;
            addr_ff <= nxt_addr;
            wdata_ff <= nxt_wdata;
            write_ff <= nxt_write;
            byte_ff <= nxt_byte;
            skew_ff <= nxt_skew;
            pok_prev_ff <= nxt_pok_prev;
            dal_ff <= nxt_dal;
            dal_oe_ff <= nxt_dal_oe;
            sync_ff <= nxt_sync;
            din_ff <= nxt_din;
            dout_ff <= nxt_dout;
            wtbt_ff <= nxt_wtbt;
            grant_ff <= nxt_grant;
            req_ready_ff <= nxt_req_ready;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            trap_ff <= nxt_trap;
            trap_vector_ff <= nxt_trap_vector;
        end
    end
endmodule

// [bus_pkg.sv]
// shared constants and types for the backplane bus handshake
package bus_pkg;
    localparam int DATA_W = 16;
    localparam logic [15:0] EVENT_VECTOR = 16'h0040;
    localparam logic [15:0] POWER_FAIL_VECTOR = 16'h0018;
    localparam int PSW_PRIO_BIT = 7;
    localparam logic [15:0] PSW_RESET = 16'h0000;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [1:0] DESKEW_CYCLES = 2'h2;
    localparam logic [1:0] DESKEW_RESET = 2'h0;

    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_ADDR = 3'b001,
        M_SKEW = 3'b011,
        M_STRB = 3'b010,
        M_DONE = 3'b110,
        M_DMA = 3'b111
    } master_state_e;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_ADDR = 2'b01,
        S_RPLY = 2'b11,
        S_WAIT = 2'b10
    } slave_state_e;
endpackage

// [bus_if.sv]
// backplane bus signals between processor master and slave modules
`timescale 1ns/100ps
interface bus_if;
    logic [15:0] dal_m;
    logic dal_m_oe;
    logic [15:0] dal_s;
    logic dal_s_oe;
    logic [15:0] mux_data_address_lines;
    logic address_sync;
    logic input_data_strobe;
    logic output_data_strobe;
    logic write_byte_select;
    logic slave_reply;
    logic dma_request;
    logic dma_grant_out;
    logic dma_select_ack;
    logic power_ok;
    logic external_event_request;

    // wired bus level worked out from the drive enables
    assign mux_data_address_lines = dal_m_oe ? dal_m : (dal_s_oe ? dal_s : 16'h0000);

    modport master (
        input mux_data_address_lines,
        output dal_m,
        output dal_m_oe,
        output address_sync,
        output input_data_strobe,
        output output_data_strobe,
        output write_byte_select,
        input slave_reply,
        input dma_request,
        output dma_grant_out,
        input dma_select_ack,
        input power_ok,
        input external_event_request
    );
    modport slave (
        input mux_data_address_lines,
        output dal_s,
        output dal_s_oe,
        input address_sync,
        input input_data_strobe,
        input output_data_strobe,
        input write_byte_select,
        output slave_reply,
        output dma_request,
        input dma_grant_out,
        output dma_select_ack
    );
endinterface

// [bus_slave.sv]
// slave memory/peripheral end of the backplane bus, with dma requester
`timescale 1ns/100ps
module bus_slave #(
    parameter logic [15:0] BASE_ADDR = 16'h1000,
    parameter logic [15:0] ADDR_MASK = 16'hFFFE
) (
    input wire logic clk,
    input wire logic arst_n,
    bus_if.slave bus,
    input wire logic [15:0] read_data,
    input wire logic dma_want,
    output logic [15:0] write_data_ff,
    output logic write_strobe_ff,
    output logic write_byte_ff,
    output logic dma_owner_ff
);
    bus_pkg::slave_state_e state_ff, nxt_state;
    logic sel_ff, nxt_sel;
    logic [15:0] dal_ff, nxt_dal;
    logic dal_oe_ff, nxt_dal_oe;
    logic reply_ff, nxt_reply;
    logic dmr_ff, nxt_dmr;
    logic nxt_owner, nxt_wstrobe, nxt_wbyte;
    logic [15:0] nxt_wdata;

    assign bus.dal_s = dal_ff;
    assign bus.dal_s_oe = dal_oe_ff;
    assign bus.slave_reply = reply_ff;
    assign bus.dma_request = dmr_ff;
    assign bus.dma_select_ack = dma_owner_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_sel = sel_ff;
        nxt_dal = dal_ff;
        nxt_dal_oe = dal_oe_ff;
        nxt_reply = reply_ff;
        nxt_wdata = write_data_ff;
        nxt_wstrobe = 1'b0;
        nxt_wbyte = write_byte_ff;
        nxt_dmr = dmr_ff;
        nxt_owner = dma_owner_ff;
        // grant seen: drop request, take the bus
        if (dmr_ff && bus.dma_grant_out) begin
            nxt_dmr = 1'b0;
            nxt_owner = 1'b1;
        end else if (dma_owner_ff && !dma_want) begin
            nxt_owner = 1'b0;
        end else if (dma_want && !dma_owner_ff && !bus.dma_grant_out) begin
            nxt_dmr = 1'b1;
        end
        unique case (state_ff)
            bus_pkg::S_IDLE: begin
                if (!bus.address_sync) begin
                    nxt_state = bus_pkg::S_ADDR;
                end
            end
            bus_pkg::S_ADDR: begin
                // latch the address at the sync edge only
                if (bus.address_sync) begin
                    nxt_sel = ((bus.mux_data_address_lines ^ BASE_ADDR) & ADDR_MASK)
                        == 16'h0000;
                    nxt_state = bus_pkg::S_RPLY;
                end
            end
            bus_pkg::S_RPLY: begin
                if (!bus.address_sync) begin
                    nxt_sel = 1'b0;
                    nxt_state = bus_pkg::S_ADDR;
                end else if (sel_ff && bus.input_data_strobe) begin
                    nxt_dal = read_data;
                    nxt_dal_oe = 1'b1;
                    nxt_reply = 1'b1;
                    nxt_state = bus_pkg::S_WAIT;
                end else if (sel_ff && bus.output_data_strobe) begin
                    nxt_wdata = bus.mux_data_address_lines;
                    nxt_wbyte = bus.write_byte_select;
                    nxt_wstrobe = 1'b1;
                    nxt_reply = 1'b1;
                    nxt_state = bus_pkg::S_WAIT;
                end
            end
            bus_pkg::S_WAIT: begin
                if (!bus.input_data_strobe && !bus.output_data_strobe) begin
                    nxt_reply = 1'b0;
                    nxt_dal_oe = 1'b0;
                    nxt_state = bus_pkg::S_RPLY;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= bus_pkg::S_IDLE;
            sel_ff <= 1'b0;
            dal_ff <= bus_pkg::DATA_RESET;
            dal_oe_ff <= 1'b0;
            reply_ff <= 1'b0;
            dmr_ff <= 1'b0;
            dma_owner_ff <= 1'b0;
            write_data_ff <= bus_pkg::DATA_RESET;
            write_strobe_ff <= 1'b0;
            write_byte_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sel_ff <= nxt_sel;
            dal_ff <= nxt_dal;
            dal_oe_ff <= nxt_dal_oe;
            reply_ff <= nxt_reply;
            dmr_ff <= nxt_dmr;
            dma_owner_ff <= nxt_owner;
            write_data_ff <= nxt_wdata;
            write_strobe_ff <= nxt_wstrobe;
            write_byte_ff <= nxt_wbyte;
        end
    end
endmodule

// [bus_props.sv]
// concurrent checks on the backplane bus handshake
`timescale 1ns/100ps
module bus_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] mux_data_address_lines,
    input wire logic dal_m_oe,
    input wire logic dal_s_oe,
    input wire logic address_sync,
    input wire logic input_data_strobe,
    input wire logic output_data_strobe,
    input wire logic write_byte_select,
    input wire logic slave_reply,
    input wire logic dma_request,
    input wire logic dma_grant_out,
    input wire logic dma_select_ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_out_start;
        $rose(output_data_strobe);
    endsequence
    sequence s_answered;
        output_data_strobe && slave_reply;
    endsequence
    property p_dout_valid;
        output_data_strobe |-> dal_m_oe && address_sync;
    endproperty
    a_dout_valid: assert property (p_dout_valid) else $error("strobe without data");
    property p_deskew;
        s_out_start |-> $past(address_sync, 2) && $stable(mux_data_address_lines);
    endproperty
    a_deskew: assert property (p_deskew) else $error("strobe not after data");
    property p_out_reply;
        s_out_start |-> ##[1:4] slave_reply;
    endproperty
    a_out_reply: assert property (p_out_reply) else $error("no reply to output");
    property p_in_reply;
        $rose(input_data_strobe) |-> ##[1:4] slave_reply;
    endproperty
    a_in_reply: assert property (p_in_reply) else $error("no reply to input");
    property p_reply_cause;
        $rose(slave_reply) |-> address_sync && (output_data_strobe || input_data_strobe);
    endproperty
    a_reply_cause: assert property (p_reply_cause) else $error("reply without strobe");
    property p_read_drive;
        input_data_strobe && slave_reply |-> dal_s_oe && !dal_m_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("reply without data");
    property p_sync_hold;
        address_sync && (output_data_strobe || input_data_strobe) |=> address_sync;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("sync dropped early");
    property p_wtbt_lead;
        $rose(address_sync) |=> input_data_strobe != $past(write_byte_select);
    endproperty
    a_wtbt_lead: assert property (p_wtbt_lead) else $error("write mark wrong");
    property p_strobe_drop;
        s_answered |-> ##[1:2] !output_data_strobe;
    endproperty
    a_strobe_drop: assert property (p_strobe_drop) else $error("strobe held");
    property p_cycle_end;
        $fell(address_sync) |-> !slave_reply;
    endproperty
    a_cycle_end: assert property (p_cycle_end) else $error("cycle ended in reply");
    property p_ack_grant;
        $rose(dma_select_ack) |-> $past(dma_grant_out) && !dma_request;
    endproperty
    a_ack_grant: assert property (p_ack_grant) else $error("ack without grant");
    property p_grant_idle;
        dma_grant_out |-> !address_sync;
    endproperty
    a_grant_idle: assert property (p_grant_idle) else $error("grant while busy");
    property p_reply_idle;
        !address_sync |-> !slave_reply;
    endproperty
    a_reply_idle: assert property (p_reply_idle) else $error("reply while idle");
endmodule

// [async_backplane_bus_handshake_bench.sv]
// self-checking bench joining master and slave across the bus interface
`timescale 1ns/100ps
module async_backplane_bus_handshake_bench;
    logic clk, arst_n, req_valid, req_write, req_byte, dma_want;
    logic [15:0] req_addr, req_wdata, psw, read_data;
    logic req_ready_ff, done_ff, trap_ff, write_strobe_ff, write_byte_ff, dma_owner_ff;
    logic [15:0] rdata_ff, trap_vector_ff, write_data_ff;
    int n_fail, comparisons, cycles;
    logic [16:0] wr_seen[$];
    bus_if bus ();
    bus_master bus_master_inst (.clk(clk), .arst_n(arst_n), .bus(bus.master),
        .req_valid(req_valid), .req_write(req_write), .req_byte(req_byte),
        .req_addr(req_addr), .req_wdata(req_wdata), .psw(psw), .req_ready_ff(req_ready_ff),
        .done_ff(done_ff), .rdata_ff(rdata_ff), .trap_ff(trap_ff),
        .trap_vector_ff(trap_vector_ff));
    bus_slave bus_slave_inst (.clk(clk), .arst_n(arst_n), .bus(bus.slave),
        .read_data(read_data), .dma_want(dma_want), .write_data_ff(write_data_ff),
        .write_strobe_ff(write_strobe_ff), .write_byte_ff(write_byte_ff),
        .dma_owner_ff(dma_owner_ff));
    bus_props bus_props_inst (.clk(clk), .arst_n(arst_n),
        .mux_data_address_lines(bus.mux_data_address_lines), .dal_m_oe(bus.dal_m_oe),
        .dal_s_oe(bus.dal_s_oe), .address_sync(bus.address_sync),
        .input_data_strobe(bus.input_data_strobe), .output_data_strobe(bus.output_data_strobe),
        .write_byte_select(bus.write_byte_select), .slave_reply(bus.slave_reply),
        .dma_request(bus.dma_request), .dma_grant_out(bus.dma_grant_out),
        .dma_select_ack(bus.dma_select_ack));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic transfer(input logic wr, input logic bt, input logic [15:0] a,
                            input logic [15:0] d);
        int k;
        logic [16:0] got;
        k = 0;
        while (req_ready_ff !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        req_write = wr;
        req_byte = bt;
        req_addr = a;
        req_wdata = d;
        read_data = d;
        req_valid = 1'b1;
        tick(1);
        req_valid = 1'b0;
        k = 0;
        while (done_ff !== 1'b1 && k < 40) begin
            tick(1);
            k++;
        end
        check({15'h0, done_ff}, 16'h0001);
        if (wr) begin
            check(16'(wr_seen.size()), 16'h0001);
            got = (wr_seen.size() > 0) ? wr_seen.pop_front() : 17'h00000;
            check(got[15:0], d);
            check({15'h0, got[16]}, {15'h0, bt});
        end else begin
            check(rdata_ff, d);
            check(16'(wr_seen.size()), 16'h0000);
        end
        tick(1);
    endtask
    task automatic expect_trap(input logic want, input logic [15:0] vec);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 6; k++) begin
            if (trap_ff === 1'b1 && !seen) begin
                seen = 1'b1;
                check(trap_vector_ff, vec);
            end
            tick(1);
        end
        check({15'h0, seen}, {15'h0, want});
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // write pulses are one cycle, so they are queued as they fly past
    always @(posedge clk) begin
        #1;
        if (write_strobe_ff === 1'b1) begin
            wr_seen.push_back({write_byte_ff, write_data_ff});
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        int k;
        void'($urandom(83755));
        {arst_n, req_valid, req_write, req_byte, dma_want} = 5'h00;
        {req_addr, req_wdata, read_data} = 48'h0;
        psw = 16'h0080;
        bus.power_ok = 1'b0;
        bus.external_event_request = 1'b0;
        tick(10);
        arst_n = 1'b1;
        bus.power_ok = 1'b1;
        tick(2);
        for (int i = 0; i < 12; i++) begin
            transfer(1'($urandom), 1'($urandom), {15'h0800, 1'($urandom)}, 16'($urandom));
        end
        bus.external_event_request = 1'b1;
        expect_trap(1'b0, 16'h0000);
        psw = 16'h0000;
        expect_trap(1'b1, 16'h0040);
        bus.external_event_request = 1'b0;
        psw = 16'h0080;
        tick(3);
        bus.power_ok = 1'b0;
        expect_trap(1'b1, bus_pkg::POWER_FAIL_VECTOR);
        bus.power_ok = 1'b1;
        tick(2);
        dma_want = 1'b1;
        k = 0;
        while (dma_owner_ff !== 1'b1 && k < 20) begin
            tick(1);
            k++;
        end
        check({15'h0, dma_owner_ff}, 16'h0001);
        check({15'h0, req_ready_ff}, 16'h0000);
        dma_want = 1'b0;
        tick(6);
        check({15'h0, dma_owner_ff}, 16'h0000);
        transfer(1'b0, 1'b0, 16'h1000, 16'($urandom));
        tally_and_finish();
    end
endmodule
